/* hdl/load_unit_defs.svh */
// constants for the load execution unit
`ifndef LOAD_UNIT_DEFS_SVH
`define LOAD_UNIT_DEFS_SVH
`define OP_SIGNED_HALF 6'h21
`define OP_UNSIGNED_HALF 6'h25
`define OP_LINKED_WORD 6'h30
`define OP_UPPER_IMM 6'h0f
`define OP_PLAIN_WORD 6'h23
`define OP_LEFT_MERGE 6'h22
`define OP_RIGHT_MERGE 6'h26
`define OP_FIELD_HI 31
`define OP_FIELD_LO 26
`define BASE_FIELD_HI 25
`define BASE_FIELD_LO 21
`define DEST_FIELD_HI 20
`define DEST_FIELD_LO 16
`define IMM_FIELD_HI 15
`define IMM_FIELD_LO 0
`define LINK_FLAG_RESET 1'b0
`endif

/* hdl/load_unit_pkg.sv */
// types for the load execution unit
package load_unit_pkg;
  typedef enum logic [2:0] {
    OPK_NONE = 3'h0,
    OPK_SIGNED_HALF = 3'h1,
    OPK_UNSIGNED_HALF = 3'h2,
    OPK_PLAIN_WORD = 3'h3,
    OPK_LINKED_WORD = 3'h4,
    OPK_UPPER_IMM = 3'h5,
    OPK_LEFT_MERGE = 3'h6
  } op_kind_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } load_state_e;
endpackage

/* hdl/load_data_align.sv */
// lane selection, extension and merge of a fetched memory word
`timescale 1ns/1ps
`default_nettype none
module load_data_align
  import load_unit_pkg::*;
(
  input wire load_unit_pkg::op_kind_e i_kind,
  input wire logic [1:0] i_addr_low,
  input wire logic i_big_endian,
  input wire logic [31:0] i_mem_word,
  input wire logic [31:0] i_dest_old,
  output logic [31:0] o_result
);
  logic [1:0] lane;
  logic [15:0] half;
  logic [1:0] byte_sel;
  logic [31:0] merged;

  // halfword lane: (addr1 ^ big endian) || 0
  assign lane = {i_addr_low[1] ^ i_big_endian, 1'b0}; // [RULE_04]
  assign half = lane[1] ? i_mem_word[31:16] : i_mem_word[15:0]; // [RULE_04]
  // byte = addr ^ big endian on both bits
  assign byte_sel = i_addr_low ^ {2{i_big_endian}}; // [RULE_17]

  always_comb begin
    merged = i_dest_old;
    // top (byte+1) bytes from memory low bytes, rest kept
    unique case (byte_sel) // [RULE_16]
      2'b00: merged = {i_mem_word[7:0], i_dest_old[23:0]};
      2'b01: merged = {i_mem_word[15:0], i_dest_old[15:0]};
      2'b10: merged = {i_mem_word[23:0], i_dest_old[7:0]};
      2'b11: merged = i_mem_word;
    endcase
  end

  always_comb begin
    o_result = i_mem_word;
    unique case (i_kind)
      OPK_SIGNED_HALF: o_result = {{16{half[15]}}, half}; // [RULE_01]
      OPK_UNSIGNED_HALF: o_result = {16'h0000, half}; // [RULE_03]
      OPK_LEFT_MERGE: o_result = merged; // [RULE_16]
      default: o_result = i_mem_word; // [RULE_06]
    endcase
  end
endmodule
`default_nettype wire

/* hdl/load_unit.sv */
// load execution unit: halfword, word, linked, upper-immediate, left merge
// Summary of operation
// (RULE_01) signed half: sign-extend fetched halfword
// (RULE_02) halfword address bit zero set: address error
// (RULE_03) unsigned half: zero-extend fetched halfword
// (RULE_04) lane is addr1 xor big endian
// (RULE_05) plain word misaligned: address error
// (RULE_06) word loads write full fetched word
// (RULE_07) linked load sets link flag after write
// (RULE_08) one sequence; new linked load replaces
// (RULE_09) conditional store ends the sequence
// (RULE_10) linked load never kills remote store
// (RULE_11) software links only cached locations
// (RULE_12) linked word misaligned: address error
// (RULE_13) linked load opcode 110000 decoded
// (RULE_14) abandoned sequence needs no cleanup
// (RULE_15) upper immediate: imm then zeros, no exception
// (RULE_16) left merge fills upper bytes, keeps rest
// (RULE_17) merge bytes from address and endianness
// (RULE_18) back-to-back merge uses forwarded data
// (RULE_19) faulting load leaves dest and flag
`timescale 1ns/1ps
`default_nettype none
`include "load_unit_defs.svh"
module load_unit
  import load_unit_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_issue_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_base_value,
  input wire logic [31:0] i_dest_value,
  input wire logic i_big_endian,
  input wire logic i_mem_ready,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_mem_fault,
  input wire logic i_store_cond_done,
  input wire logic i_exc_return,
  output logic o_issue_ready,
  output logic o_mem_req,
  output logic [31:0] o_mem_addr,
  output logic o_wb_valid,
  output logic [4:0] o_wb_gpr,
  output logic [31:0] o_wb_data,
  output logic o_addr_error,
  output logic o_bus_error,
  output logic o_link_flag,
  output logic o_store_cond_ok
);
  import load_unit_pkg::*;

  function automatic op_kind_e decode_kind(input logic [5:0] op);
    op_kind_e k;
    k = OPK_NONE;
    unique case (op)
      `OP_UNSIGNED_HALF: k = OPK_UNSIGNED_HALF;
      `OP_LINKED_WORD: k = OPK_LINKED_WORD; // [RULE_13]
      `OP_UPPER_IMM: k = OPK_UPPER_IMM;
      `OP_PLAIN_WORD: k = OPK_PLAIN_WORD;
      `OP_LEFT_MERGE: k = OPK_LEFT_MERGE;
      `OP_SIGNED_HALF: k = OPK_SIGNED_HALF;
      default: k = OPK_NONE;
    endcase
    return k;
  endfunction

  function automatic logic misaligned(input op_kind_e k,
                                      input logic [1:0] a);
    logic bad;
    bad = 1'b0;
    unique case (k)
      OPK_SIGNED_HALF, OPK_UNSIGNED_HALF: bad = a[0]; // [RULE_02]
      OPK_PLAIN_WORD: bad = |a; // [RULE_05]
      OPK_LINKED_WORD: bad = |a; // [RULE_12]
      default: bad = 1'b0; // [RULE_15]
    endcase
    return bad;
  endfunction

  op_kind_e dec_kind;
  logic [31:0] eff_addr;
  logic [31:0] imm_ext;
  logic [4:0] dest_field;
  logic issue_fire;
  logic align_bad;
  load_state_e state_reg;
  op_kind_e kind_reg;
  logic [31:0] addr_reg;
  logic [31:0] dest_old_reg;
  logic [4:0] gpr_reg;
  logic big_reg;
  logic [31:0] aligned_data;
  logic [31:0] last_wb_data_reg;
  logic [4:0] last_wb_gpr_reg;
  logic last_wb_valid_reg;
  logic [31:0] merge_base;
  logic link_reg;
  logic wb_valid_reg;
  logic [4:0] wb_gpr_reg;
  logic [31:0] wb_data_reg;
  logic addr_err_reg;
  logic bus_err_reg;
  logic sc_ok_reg;
  logic set_link;

  assign dec_kind = decode_kind(i_instr[`OP_FIELD_HI:`OP_FIELD_LO]);
  assign imm_ext = {{16{i_instr[`IMM_FIELD_HI]}},
                    i_instr[`IMM_FIELD_HI:`IMM_FIELD_LO]};
  assign eff_addr = i_base_value + imm_ext; // [RULE_01]
  assign dest_field = i_instr[`DEST_FIELD_HI:`DEST_FIELD_LO];
  assign o_issue_ready = (state_reg == ST_IDLE);
  assign issue_fire = i_issue_valid && o_issue_ready &&
                      (dec_kind != OPK_NONE);
  assign align_bad = misaligned(dec_kind, eff_addr[1:0]);

  // memory side sees the word-aligned address; lane chosen on return
  assign o_mem_req = (state_reg == ST_WAIT);
  assign o_mem_addr = {addr_reg[31:2], 2'b00};

  // merge source picked at issue: a write in flight or just done to the
  // same gpr beats the register file value, which may still be stale
  assign merge_base = (wb_valid_reg && wb_gpr_reg == dest_field) ?
                      wb_data_reg :
                      (last_wb_valid_reg && last_wb_gpr_reg == dest_field) ?
                      last_wb_data_reg : i_dest_value; // [RULE_18]

  load_data_align u_align (
    .i_kind(kind_reg),
    .i_addr_low(addr_reg[1:0]),
    .i_big_endian(big_reg),
    .i_mem_word(i_mem_rdata),
    .i_dest_old(dest_old_reg),
    .o_result(aligned_data)
  );

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (issue_fire && !align_bad && dec_kind != OPK_UPPER_IMM) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (i_mem_ready) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      kind_reg <= OPK_NONE;
      addr_reg <= 32'h0000_0000;
      dest_old_reg <= 32'h0000_0000;
      gpr_reg <= 5'h00;
      big_reg <= 1'b0;
    end else if (issue_fire) begin
      kind_reg <= dec_kind;
      addr_reg <= eff_addr;
      dest_old_reg <= merge_base; // [RULE_18]
      gpr_reg <= dest_field;
      big_reg <= i_big_endian; // [RULE_17]
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wb_valid_reg <= 1'b0;
      wb_gpr_reg <= 5'h00;
      wb_data_reg <= 32'h0000_0000;
      addr_err_reg <= 1'b0;
      bus_err_reg <= 1'b0;
    end else begin
      wb_valid_reg <= 1'b0;
      addr_err_reg <= 1'b0;
      bus_err_reg <= 1'b0;
      if (issue_fire && align_bad) begin
        addr_err_reg <= 1'b1; // [RULE_19]
      end else if (issue_fire && dec_kind == OPK_UPPER_IMM) begin
        wb_valid_reg <= 1'b1;
        wb_gpr_reg <= dest_field;
        wb_data_reg <= {i_instr[`IMM_FIELD_HI:`IMM_FIELD_LO],
                        16'h0000}; // [RULE_15]
      end else if (state_reg == ST_WAIT && i_mem_ready) begin
        if (i_mem_fault) begin
          bus_err_reg <= 1'b1; // [RULE_19]
        end else begin
          wb_valid_reg <= 1'b1;
          wb_gpr_reg <= gpr_reg;
          wb_data_reg <= aligned_data; // [RULE_06]
        end
      end
    end
  end

  // remember the last write for back-to-back merge forwarding
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      last_wb_valid_reg <= 1'b0;
      last_wb_gpr_reg <= 5'h00;
      last_wb_data_reg <= 32'h0000_0000;
    end else if (wb_valid_reg) begin
      last_wb_valid_reg <= 1'b1;
      last_wb_gpr_reg <= wb_gpr_reg;
      last_wb_data_reg <= wb_data_reg; // [RULE_18]
    end else if (issue_fire) begin
      last_wb_valid_reg <= 1'b0;
    end
  end

  assign set_link = state_reg == ST_WAIT && i_mem_ready && !i_mem_fault &&
                    kind_reg == OPK_LINKED_WORD;

  // only local events touch the flag; remote traffic never clears it
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      link_reg <= `LINK_FLAG_RESET;
    end else if (set_link) begin
      link_reg <= 1'b1; // [RULE_07] [RULE_08] [RULE_10]
    end else if (i_store_cond_done || i_exc_return) begin
      link_reg <= 1'b0; // [RULE_09]
    end
  end

  // abandoned sequences simply linger until replaced or cleared by an exception return [RULE_14]
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sc_ok_reg <= 1'b0;
    end else begin
      sc_ok_reg <= i_store_cond_done && link_reg; // [RULE_09]
    end
  end

  assign o_wb_valid = wb_valid_reg;
  assign o_wb_gpr = wb_gpr_reg;
  assign o_wb_data = wb_data_reg;
  assign o_addr_error = addr_err_reg;
  assign o_bus_error = bus_err_reg;
  assign o_link_flag = link_reg;
  assign o_store_cond_ok = sc_ok_reg;

  AST_HALF_ALIGN: assert property (@(posedge i_clock) // [RULE_02]
    disable iff (i_rst)
    issue_fire && (dec_kind == OPK_SIGNED_HALF ||
    dec_kind == OPK_UNSIGNED_HALF) && eff_addr[0] |=> o_addr_error)
    else $error("halfword misalignment not flagged");
  AST_WORD_ALIGN: assert property (@(posedge i_clock) // [RULE_05]
    disable iff (i_rst)
    issue_fire && dec_kind == OPK_PLAIN_WORD && eff_addr[1:0] != 2'b00
    |=> o_addr_error && !o_wb_valid)
    else $error("word misalignment not flagged");
  AST_LINK_ALIGN: assert property (@(posedge i_clock) // [RULE_12]
    disable iff (i_rst)
    issue_fire && dec_kind == OPK_LINKED_WORD && eff_addr[1:0] != 2'b00
    |=> o_addr_error)
    else $error("linked misalignment not flagged");
  AST_UPPER_IMM: assert property (@(posedge i_clock) // [RULE_15]
    disable iff (i_rst)
    issue_fire && dec_kind == OPK_UPPER_IMM |=> o_wb_valid &&
    o_wb_data[15:0] == 16'h0000 && !o_addr_error)
    else $error("upper immediate result wrong");
  AST_LINK_SET: assert property (@(posedge i_clock) // [RULE_07]
    disable iff (i_rst)
    set_link |=> o_link_flag && o_wb_valid)
    else $error("link flag not set with write");
  AST_FAULT_KEEP: assert property (@(posedge i_clock) // [RULE_19]
    disable iff (i_rst)
    o_addr_error || o_bus_error |-> !o_wb_valid &&
    o_link_flag == $past(o_link_flag))
    else $error("fault changed state");
  AST_UNSIGNED_ZERO: assert property (@(posedge i_clock) // [RULE_03]
    disable iff (i_rst)
    state_reg == ST_WAIT && i_mem_ready && !i_mem_fault &&
    kind_reg == OPK_UNSIGNED_HALF |=> o_wb_data[31:16] == 16'h0000)
    else $error("unsigned half not zero extended");
  AST_SIGNED_EXT: assert property (@(posedge i_clock) // [RULE_01]
    disable iff (i_rst)
    state_reg == ST_WAIT && i_mem_ready && !i_mem_fault &&
    kind_reg == OPK_SIGNED_HALF |=>
    o_wb_data[31:16] == {16{o_wb_data[15]}})
    else $error("signed half not sign extended");
  AST_LANE: assert property (@(posedge i_clock) // [RULE_04]
    disable iff (i_rst)
    state_reg == ST_WAIT && i_mem_ready && !i_mem_fault &&
    kind_reg == OPK_UNSIGNED_HALF && (addr_reg[1] ^ big_reg) |=>
    o_wb_data[15:0] == $past(i_mem_rdata[31:16]))
    else $error("wrong halfword lane");
  AST_SC_CLEAR: assert property (@(posedge i_clock) // [RULE_09]
    disable iff (i_rst)
    i_store_cond_done && !set_link |=> !o_link_flag)
    else $error("conditional store left link set");
  AST_MERGE_FWD: assert property (@(posedge i_clock) // [RULE_18]
    disable iff (i_rst)
    issue_fire && dec_kind == OPK_LEFT_MERGE && !wb_valid_reg &&
    last_wb_valid_reg && last_wb_gpr_reg == dest_field |=>
    dest_old_reg == $past(last_wb_data_reg))
    else $error("merge missed the forwarded data");
  AST_MERGE_KEEP: assert property (@(posedge i_clock) // [RULE_16]
    disable iff (i_rst)
    state_reg == ST_WAIT && i_mem_ready && !i_mem_fault &&
    kind_reg == OPK_LEFT_MERGE && addr_reg[1:0] == {2{big_reg}} |=>
    o_wb_data == {$past(i_mem_rdata[7:0]), $past(dest_old_reg[23:0])})
    else $error("left merge of one byte wrong");
  AST_MERGE_FULL: assert property (@(posedge i_clock) // [RULE_17]
    disable iff (i_rst)
    state_reg == ST_WAIT && i_mem_ready && !i_mem_fault &&
    kind_reg == OPK_LEFT_MERGE && addr_reg[1:0] == ~{2{big_reg}} |=>
    o_wb_data == $past(i_mem_rdata))
    else $error("left merge of four bytes wrong");
  AST_WORD_DATA: assert property (@(posedge i_clock) // [RULE_06]
    disable iff (i_rst)
    state_reg == ST_WAIT && i_mem_ready && !i_mem_fault &&
    (kind_reg == OPK_PLAIN_WORD || kind_reg == OPK_LINKED_WORD) |=>
    o_wb_data == $past(i_mem_rdata))
    else $error("word load data wrong");
  AST_BUS_FAULT: assert property (@(posedge i_clock) // [RULE_19]
    disable iff (i_rst)
    state_reg == ST_WAIT && i_mem_ready && i_mem_fault |=>
    o_bus_error && !o_wb_valid)
    else $error("bus fault not reported or write made");
  AST_SC_OK: assert property (@(posedge i_clock) // [RULE_09]
    disable iff (i_rst)
    i_store_cond_done && o_link_flag |=> o_store_cond_ok)
    else $error("conditional store success not reported");
  AST_UPPER_DATA: assert property (@(posedge i_clock) // [RULE_15]
    disable iff (i_rst)
    issue_fire && dec_kind == OPK_UPPER_IMM |=>
    o_wb_data == {$past(i_instr[`IMM_FIELD_HI:`IMM_FIELD_LO]), 16'h0000})
    else $error("upper immediate data wrong");

  COV_LINKED: cover property (@(posedge i_clock) disable iff (i_rst)
    set_link ##[1:20] i_store_cond_done);
  COV_MERGE: cover property (@(posedge i_clock) disable iff (i_rst)
    issue_fire && dec_kind == OPK_LEFT_MERGE);
  COV_ADDR_ERR: cover property (@(posedge i_clock) disable iff (i_rst)
    o_addr_error);
  COV_BUS_ERR: cover property (@(posedge i_clock) disable iff (i_rst)
    o_bus_error);
  COV_FWD_MERGE: cover property (@(posedge i_clock) disable iff (i_rst)
    issue_fire && dec_kind == OPK_LEFT_MERGE && last_wb_valid_reg);
endmodule
`default_nettype wire

/* test/mem_path_model.sv */
// memory and translation path model answering load requests
`timescale 1ns/1ps
`default_nettype none
module mem_path_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [31:0] i_word,
  input wire logic i_fault,
  input wire logic [1:0] i_delay,
  output logic o_ready,
  output logic [31:0] o_rdata,
  output logic o_fault
);
  logic [1:0] wait_reg;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_ready <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_fault <= 1'b0;
      wait_reg <= 2'h0;
    end else if (i_req && !o_ready && wait_reg == i_delay) begin
      o_ready <= 1'b1;
      o_rdata <= i_word;
      o_fault <= i_fault;
      wait_reg <= 2'h0;
    end else begin
      // data and fault churn outside answers so stale sampling shows
      o_ready <= 1'b0;
      o_rdata <= ~o_rdata;
      o_fault <= ~o_fault;
      wait_reg <= (i_req && !o_ready) ? wait_reg + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

/* test/load_unit_test.sv */
// self-checking bench for the load execution unit
`timescale 1ns/1ps
`default_nettype none
`include "load_unit_defs.svh"
module load_unit_test;
  localparam logic [5:0] op_signed_half = `OP_SIGNED_HALF;
  localparam logic [5:0] op_unknown = 6'h3f;
  logic i_clock, i_rst, i_issue_valid, i_big_endian, i_store_cond_done;
  logic i_exc_return, i_mem_ready, i_mem_fault, mem_fault;
  logic [31:0] i_instr, i_base_value, i_dest_value, i_mem_rdata, mem_word;
  logic [1:0] mem_delay;
  logic o_issue_ready, o_mem_req, o_wb_valid, o_addr_error, o_bus_error;
  logic o_link_flag, o_store_cond_ok;
  logic [31:0] o_mem_addr, o_wb_data;
  logic [4:0] o_wb_gpr, prev_gpr;
  logic [31:0] prev_data;
  logic flag_exp, prev_ok, amb;
  int miscompares, checks;
  logic [5:0] ops [7] = '{op_signed_half, `OP_UNSIGNED_HALF, `OP_PLAIN_WORD,
    `OP_LINKED_WORD, `OP_UPPER_IMM, `OP_LEFT_MERGE, op_unknown};

  load_unit load_unit_i (.i_clock, .i_rst, .i_issue_valid, .i_instr,
    .i_base_value, .i_dest_value, .i_big_endian, .i_mem_ready, .i_mem_rdata,
    .i_mem_fault, .i_store_cond_done, .i_exc_return, .o_issue_ready,
    .o_mem_req, .o_mem_addr, .o_wb_valid, .o_wb_gpr, .o_wb_data,
    .o_addr_error, .o_bus_error, .o_link_flag, .o_store_cond_ok);
  mem_path_model mem_path_model_i (.i_clock, .i_rst, .i_req(o_mem_req),
    .i_word(mem_word), .i_fault(mem_fault), .i_delay(mem_delay),
    .o_ready(i_mem_ready), .o_rdata(i_mem_rdata), .o_fault(i_mem_fault));

  always #12.5 i_clock = ~i_clock;

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_bit(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask

  function automatic logic [31:0] exp_data(input logic [5:0] op,
    input logic [31:0] ea, input logic [31:0] w, input logic [31:0] old,
    input logic bg, input logic [15:0] imm);
    logic [1:0] by;
    logic [31:0] h;
    h = w >> (8 * {ea[1] ^ bg, 1'b0});
    by = ea[1:0] ^ {bg, bg};
    case (op)
      op_signed_half: return {{16{h[15]}}, h[15:0]};
      `OP_UNSIGNED_HALF: return {16'h0000, h[15:0]};
      `OP_UPPER_IMM: return {imm, 16'h0000};
      `OP_LEFT_MERGE: return (w << (8 * (3 - by))) |
        (old & (32'h00ff_ffff >> (8 * by)));
      default: return w;
    endcase
  endfunction

  task automatic run_op(input logic [5:0] op, input logic [4:0] rd,
    input logic [15:0] imm, input logic [31:0] bs, input logic [31:0] dv,
    input logic [31:0] w, input logic bg, input logic f);
    logic [31:0] ea, old, ed;
    logic ad, mem, known, wb, seen;
    int n;
    ea = bs + {{16{imm[15]}}, imm};
    known = op != op_unknown;
    ad = ((op == op_signed_half || op == `OP_UNSIGNED_HALF) && ea[0]) ||
      ((op == `OP_PLAIN_WORD || op == `OP_LINKED_WORD) && ea[1:0] != 2'b00);
    mem = known && !ad && op != `OP_UPPER_IMM;
    wb = known && !ad && !(mem && f);
    // a dropped issue may or may not break forwarding; make both agree
    if (amb && prev_ok && prev_gpr == rd) dv = prev_data;
    old = (prev_ok && prev_gpr == rd) ? prev_data : dv;
    ed = exp_data(op, ea, w, old, bg, imm);
    n = 0;
    while (o_issue_ready !== 1'b1) begin
      @(negedge i_clock);
      n++;
      if (n > 40) begin
        miscompares++;
        $display("[ERR] %0t issue wait ran out", $time);
        finish_test;
      end
    end
    @(posedge i_clock);
    i_issue_valid <= 1'b1;
    i_instr <= {op, 5'h01, rd, imm};
    i_base_value <= bs;
    i_dest_value <= dv;
    i_big_endian <= bg;
    mem_word <= w;
    mem_fault <= f;
    mem_delay <= 2'($urandom_range(3));
    @(posedge i_clock);
    i_issue_valid <= 1'b0;
    seen = 1'b0;
    for (n = 0; n < 12; n++) begin
      @(negedge i_clock);
      if (o_mem_req === 1'b1 && !seen) begin
        seen = 1'b1;
        cmp_word(o_mem_addr, {ea[31:2], 2'b00});
      end
      if (o_wb_valid === 1'b1 || o_addr_error === 1'b1) break;
      if (o_bus_error === 1'b1) break;
    end
    cmp_bit(o_addr_error, ad);
    cmp_bit(o_bus_error, mem && f);
    cmp_bit(o_wb_valid, wb);
    if (wb) begin
      cmp_word(o_wb_data, ed);
      cmp_word({27'h0, o_wb_gpr}, {27'h0, rd});
    end
    if (wb && op == `OP_LINKED_WORD) flag_exp = 1'b1;
    @(negedge i_clock);
    cmp_bit(o_link_flag, flag_exp);
    amb = !known;
    if (known) begin
      prev_ok = wb;
      prev_gpr = rd;
      prev_data = ed;
    end
  endtask

  task automatic pulse_ctl(input logic s);
    @(posedge i_clock);
    if (s) i_store_cond_done <= 1'b1;
    else i_exc_return <= 1'b1;
    @(posedge i_clock);
    i_store_cond_done <= 1'b0;
    i_exc_return <= 1'b0;
    @(negedge i_clock);
    cmp_bit(o_store_cond_ok, s && flag_exp);
    flag_exp = 1'b0;
    @(negedge i_clock);
    cmp_bit(o_link_flag, flag_exp);
  endtask

  initial begin
    i_clock = 1'b0;
    i_rst = 1'b1;
    {i_issue_valid, i_big_endian, i_store_cond_done, i_exc_return} = 4'h0;
    {i_instr, i_base_value, i_dest_value, mem_word} = '0;
    {mem_fault, mem_delay, flag_exp, prev_ok, amb} = '0;
    prev_gpr = 5'h00;
    prev_data = 32'h0000_0000;
    miscompares = 0;
    checks = 0;
    void'($urandom(32'h0870));
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    cmp_bit(o_link_flag, `LINK_FLAG_RESET);
    run_op(`OP_LINKED_WORD, 5'h02, 16'h0004, 32'h0000_0100, 32'h0,
      32'h8123_4567, 1'b0, 1'b0);
    pulse_ctl(1'b1);
    pulse_ctl(1'b1);
    run_op(`OP_LINKED_WORD, 5'h01, 16'hfffc, 32'h0000_0200, 32'h0,
      32'h0bad_f00d, 1'b1, 1'b0);
    run_op(`OP_LINKED_WORD, 5'h03, 16'h0008, 32'h0000_0300, 32'h0,
      32'h1357_9bdf, 1'b0, 1'b0);
    run_op(`OP_LINKED_WORD, 5'h03, 16'h0002, 32'h0000_0300, 32'h0,
      32'h1111_2222, 1'b0, 1'b0);
    pulse_ctl(1'b0);
    run_op(`OP_PLAIN_WORD, 5'h02, 16'h0010, 32'h0000_0040, 32'h0,
      32'ha1b2_c3d4, 1'b1, 1'b0);
    run_op(`OP_LEFT_MERGE, 5'h02, 16'h0011, 32'h0000_0040, 32'h5555_5555,
      32'h0102_0304, 1'b1, 1'b0);
    repeat (400) begin
      // random linked loads stand for accesses to cached locations
      run_op(ops[$urandom_range(6)], 5'($urandom_range(3, 1)), 16'($urandom),
        $urandom, $urandom, $urandom, 1'($urandom), $urandom_range(7) == 0);
      if ($urandom_range(15) == 0) pulse_ctl(1'($urandom));
    end
    finish_test;
  end
endmodule
`default_nettype wire
